// File: wwdt_core.v
// windowed watchdog timer with apb registers, change protection and lock
// assumes the cpu supplies restart pulses, the protection window level
// and the debug halt level on pclk; the tick pin is asynchronous
//
// Contract
// - non-zero timeout code enables the watchdog
// - control and lock writable only through protection
// - control loads from fuse; enabled fuse sets lock
// - normal mode: missed restart raises system reset
// - accepted restart clears counter, new period
// - closed code zero means normal mode
// - restart during closed period raises reset
// - open follows closed; reset at open end
// - no closed period until first restart
// - lock set ignores control writes
// - lock only set; cleared only in debug
// - counting steps on each tick while enabled and not in debug halt
// - control write sets sync pending until applied
// - restart synchronises 2 ticks; extras ignored
// - unprotected write completes but changes nothing
// - closed code 1..11 gives 8..8K ticks
// - timeout code same encoding, zero is off
// - control bits 7:4 closed, 3:0 timeout
// - status lock bit 7, sync pending bit 0
// - counter steps on asynchronous 1 kHz tick
// - debug halt stops and clears counter
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "wwdt_defines.vh"

module wwdt_core (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire watchdog_tick,
	input wire restart_instruction,
	input wire change_protection_open,
	input wire debug_halt,
	input wire [7:0] boot_config_fuse,
	output reg sys_reset_req,
	output wire watchdog_enabled
);

// ----------------------------------------------------------------
// phase encoding
// ----------------------------------------------------------------
localparam [2:0] ST_OFF = 3'b001;
localparam [2:0] ST_CLOSED = 3'b010;
localparam [2:0] ST_OPEN = 3'b100;

reg [7:0] watchdog_control;
reg [7:0] active_control;
reg lock;
reg sync_pending;
reg [1:0] sync_cnt;
reg restart_busy;
reg [1:0] restart_cnt;
reg boot_loaded;
reg [2:0] state;
reg [13:0] count;
reg [2:0] next_state;
reg [13:0] next_count;
reg next_fire;
wire tick_en;
wire [9:0] reg_index;
wire setup;
wire wr_access;
wire ctrl_write;
wire hit_control;
wire hit_status;
wire apply_now;
wire restart_now;
wire [3:0] act_closed;
wire [3:0] act_open;
wire [3:0] new_closed;
wire [3:0] new_open;
wire [13:0] closed_len;
wire [13:0] open_len;
wire [13:0] count_inc;

// ----------------------------------------------------------------
// duration decode
// ----------------------------------------------------------------
function [13:0] wwdt_duration;
	input [3:0] code;
	begin
		case (code)
			4'h1: wwdt_duration = `WWDT_DUR_SHORTEST;
			4'h2: wwdt_duration = 14'h0010;
			4'h3: wwdt_duration = 14'h0020;
			4'h4: wwdt_duration = 14'h0040;
			4'h5: wwdt_duration = 14'h0080;
			4'h6: wwdt_duration = 14'h0100;
			4'h7: wwdt_duration = 14'h0200;
			4'h8: wwdt_duration = 14'h0400;
			4'h9: wwdt_duration = 14'h0800;
			4'hA: wwdt_duration = 14'h1000;
			default: wwdt_duration = `WWDT_DUR_LONGEST;
		endcase
	end
endfunction

// ----------------------------------------------------------------
// tick from the oscillator pin
// ----------------------------------------------------------------
wwdt_tick_sync u_tick (
	.pclk(pclk),
	.presetn(presetn),
	.tick_pin(watchdog_tick),
	.tick_en(tick_en)
);

// ----------------------------------------------------------------
// field views
// ----------------------------------------------------------------
assign act_closed = active_control[`WWDT_CTRL_CLOSED_HI:`WWDT_CTRL_CLOSED_LO];
assign act_open = active_control[`WWDT_CTRL_OPEN_HI:`WWDT_CTRL_OPEN_LO];
assign new_closed =
	watchdog_control[`WWDT_CTRL_CLOSED_HI:`WWDT_CTRL_CLOSED_LO];
assign new_open = watchdog_control[`WWDT_CTRL_OPEN_HI:`WWDT_CTRL_OPEN_LO];
assign closed_len = wwdt_duration(act_closed);
assign open_len = wwdt_duration(act_open);
assign count_inc = count + 14'h0001;
assign watchdog_enabled = (act_open != `WWDT_CODE_OFF);

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
assign reg_index = paddr[11:2];
assign setup = psel & ~penable;
assign wr_access = psel & penable & pwrite;
assign hit_control = (reg_index == `WWDT_IDX_CONTROL);
assign hit_status = (reg_index == `WWDT_IDX_STATUS);
assign pready = 1'b1;
assign ctrl_write = boot_loaded & wr_access & hit_control &
	change_protection_open & ~lock;

// read data is prepared in the setup cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h0000_0000;
	end else if (setup) begin
		if (hit_control)
			prdata <= {24'h00_0000, watchdog_control};
		else if (hit_status)
			prdata <= {24'h00_0000, lock, 6'h00, sync_pending};
		else
			prdata <= 32'h0000_0000;
	end
end

// unmapped indices answer with an error; writes to them are dropped
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pslverr <= 1'b0;
	end else if (setup) begin
		pslverr <= ~(hit_control | hit_status);
	end
end

// ----------------------------------------------------------------
// software control and boot load
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		watchdog_control <= 8'h00;
		boot_loaded <= 1'b0;
	end else if (!boot_loaded) begin
		watchdog_control <= boot_config_fuse;
		boot_loaded <= 1'b1;
	end else if (ctrl_write) begin
		watchdog_control <= pwdata[7:0];
	end
end

// ----------------------------------------------------------------
// sync pending tracking
// ----------------------------------------------------------------
assign apply_now = sync_pending & tick_en &
	(sync_cnt == (`WWDT_SYNC_TICKS - 2'h1));

// a write during a transfer restarts it with the new value
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync_pending <= 1'b0;
		sync_cnt <= 2'h0;
	end else if (ctrl_write) begin
		sync_pending <= 1'b1;
		sync_cnt <= 2'h0;
	end else if (sync_pending && tick_en) begin
		if (apply_now) begin
			sync_pending <= 1'b0;
			sync_cnt <= 2'h0;
		end else begin
			sync_cnt <= sync_cnt + 2'h1;
		end
	end
end

// ----------------------------------------------------------------
// lock bit
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		lock <= 1'b0;
	end else if (!boot_loaded) begin
		lock <= (boot_config_fuse[`WWDT_CTRL_OPEN_HI:`WWDT_CTRL_OPEN_LO]
			!= `WWDT_CODE_OFF);
	end else if (wr_access && hit_status
		&& change_protection_open) begin
		// software may only set it; clearing needs debug halt
		if (pwdata[`WWDT_STAT_LOCK])
			lock <= 1'b1;
		else if (debug_halt)
			lock <= 1'b0;
	end
end

// ----------------------------------------------------------------
// restart synchronisation
// ----------------------------------------------------------------
assign restart_now = restart_busy & tick_en & (restart_cnt == 2'h1);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		restart_busy <= 1'b0;
		restart_cnt <= 2'h0;
	end else if (!restart_busy) begin
		if (restart_instruction) begin
			restart_busy <= 1'b1;
			restart_cnt <= 2'h0;
		end
	end else if (tick_en) begin
		if (restart_now) begin
			restart_busy <= 1'b0;
			restart_cnt <= 2'h0;
		end else begin
			restart_cnt <= restart_cnt + 2'h1;
		end
	end
end

// ----------------------------------------------------------------
// counter and phase
// ----------------------------------------------------------------
always @* begin
	next_state = state;
	next_count = count;
	next_fire = 1'b0;
	if (debug_halt) begin
		next_count = 14'h0000;
		next_state = watchdog_enabled ? ST_OPEN : ST_OFF;
	end else if (apply_now) begin
		next_count = 14'h0000;
		if (new_open == `WWDT_CODE_OFF)
			next_state = ST_OFF;
		else if (state == ST_OFF)
			next_state = ST_OPEN;
		else if (new_closed == `WWDT_CODE_OFF)
			next_state = ST_OPEN;
		else if (act_closed == `WWDT_CODE_OFF)
			next_state = ST_OPEN;
	end else if (tick_en) begin
		case (state)
			ST_OFF: begin
				next_count = 14'h0000;
			end
			ST_CLOSED: begin
				if (restart_now) begin
					next_fire = 1'b1;
					next_count = 14'h0000;
				end else if (count_inc == closed_len) begin
					next_state = ST_OPEN;
					next_count = 14'h0000;
				end else begin
					next_count = count_inc;
				end
			end
			ST_OPEN: begin
				if (restart_now) begin
					next_count = 14'h0000;
					if (act_closed != `WWDT_CODE_OFF)
						next_state = ST_CLOSED;
					else
						next_state = ST_OPEN;
				end else if (count_inc == open_len) begin
					next_fire = 1'b1;
					next_count = 14'h0000;
				end else begin
					next_count = count_inc;
				end
			end
			default: begin
				next_state = ST_OFF;
				next_count = 14'h0000;
			end
		endcase
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		active_control <= 8'h00;
		state <= ST_OFF;
		count <= 14'h0000;
	end else if (!boot_loaded) begin
		active_control <= boot_config_fuse;
		state <= (boot_config_fuse[`WWDT_CTRL_OPEN_HI:`WWDT_CTRL_OPEN_LO]
			!= `WWDT_CODE_OFF) ? ST_OPEN : ST_OFF;
		count <= 14'h0000;
	end else begin
		if (apply_now)
			active_control <= watchdog_control;
		state <= next_state;
		count <= next_count;
	end
end

// ----------------------------------------------------------------
// reset request to the reset controller
// ----------------------------------------------------------------
// one pclk pulse; the counter keeps running after it
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		sys_reset_req <= 1'b0;
	else if (!boot_loaded)
		sys_reset_req <= 1'b0;
	else
		sys_reset_req <= next_fire;
end

endmodule
`default_nettype wire

// File: wwdt_cpu_model.sv
// cpu side model: oscillator pin, restart pulses, key window
// assumes pclk from the bench; the pin runs free of pclk
`timescale 1ns/10ps
`default_nettype none
module wwdt_cpu_model (
	input wire logic pclk,
	output logic watchdog_tick,
	output logic restart_instruction,
	output logic change_protection_open,
	output int tick_count
);
	initial begin
		watchdog_tick = 1'b0;
		restart_instruction = 1'b0;
		change_protection_open = 1'b0;
		tick_count = 0;
	end
	// free running, phase unrelated to pclk
	always #101 watchdog_tick = ~watchdog_tick;
	always @(posedge watchdog_tick) tick_count <= tick_count + 1;
	task restart;
		@(posedge pclk) restart_instruction <= 1'b1;
		@(posedge pclk) restart_instruction <= 1'b0;
	endtask
	// key opened just before the protected access, closed after it
	task key(input logic open);
		@(posedge pclk) change_protection_open <= open;
	endtask
endmodule
`default_nettype wire

// File: wwdt_defines.vh
// register map, field positions, reset values and timing counts
// assumes a 32-bit apb slave with each register in one aligned word
`ifndef WWDT_DEFINES_VH
`define WWDT_DEFINES_VH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define WWDT_IDX_CONTROL 10'h000
`define WWDT_IDX_STATUS 10'h001

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WWDT_CTRL_CLOSED_HI 7
`define WWDT_CTRL_CLOSED_LO 4
`define WWDT_CTRL_OPEN_HI 3
`define WWDT_CTRL_OPEN_LO 0
`define WWDT_STAT_LOCK 7
`define WWDT_STAT_SYNC 0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define WWDT_STATUS_RESET 8'h00
`define WWDT_CODE_OFF 4'h0
`define WWDT_CODE_MAX 4'hB

// ----------------------------------------------------------------
// timing: tick rate in Hz, counts in watchdog ticks
// ----------------------------------------------------------------
`define WWDT_TICK_RATE_HZ 1000
`define WWDT_SYNC_TICKS 2'h2
`define WWDT_DUR_SHORTEST 14'h0008
`define WWDT_DUR_LONGEST 14'h2000

`endif

// File: wwdt_props.sv
// port checker for the windowed watchdog core
// assumes the ports of wwdt_core, bound from the bench
`timescale 1ns/10ps
`default_nettype none
module wwdt_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire debug_halt,
	input wire sys_reset_req,
	input wire watchdog_enabled
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence bad_idx_s;
		setup_s ##0 paddr[11:2] > 10'h001;
	endsequence
	ready_high_a:
		assert property (pready) else $error("pready low");
	pulse_one_a:
		assert property ($rose(sys_reset_req) |=> !sys_reset_req)
		else $error("reset pulse longer than one cycle");
	unmapped_err_a:
		assert property (bad_idx_s |=> pslverr)
		else $error("no error on unmapped index");
	mapped_ok_a:
		assert property (setup_s ##0 paddr[11:2] <= 10'h001 |=> !pslverr)
		else $error("error on mapped index");
	upper_zero_a:
		assert property (setup_s |=> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	unmapped_zero_a:
		assert property (bad_idx_s ##0 !pwrite |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	err_hold_a:
		assert property (!psel |=> $stable(pslverr))
		else $error("error flag moved while idle");
	halt_quiet_a:
		assert property (debug_halt [*4] |-> !sys_reset_req)
		else $error("reset raised in debug halt");
	off_quiet_a:
		assert property (!watchdog_enabled [*4] |-> !sys_reset_req)
		else $error("reset raised while disabled");
endmodule
`default_nettype wire

// File: wwdt_tb.sv
// self-checking bench for the windowed watchdog core
// assumes wwdt_core, wwdt_cpu_model and wwdt_props alongside
`timescale 1ns/10ps
`default_nettype none
module wwdt_tb;
	typedef struct packed {
		logic p;
		logic [11:0] a;
		logic [7:0] d, st, rv;
		logic e;
	} wwdt_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic debug_halt = 1'b0;
	logic [7:0] fuse = 8'h00;
	logic [31:0] prdata, rd;
	logic pready, pslverr, sys_reset_req, watchdog_enabled, err;
	logic watchdog_tick, restart, prot;
	int tick_count, t0, miscompares = 0, samples_checked = 0;
	wwdt_row_t rows [8] = '{
		'{1'b0, 12'h000, 8'h01, 8'h00, 8'h00, 1'b0},
		'{1'b1, 12'h000, 8'h01, 8'h01, 8'h01, 1'b0},
		'{1'b1, 12'h000, 8'h00, 8'h01, 8'h00, 1'b0},
		'{1'b1, 12'h008, 8'hff, 8'h00, 8'h00, 1'b1},
		'{1'b0, 12'h004, 8'h80, 8'h00, 8'h00, 1'b0},
		'{1'b1, 12'h004, 8'h81, 8'h80, 8'h80, 1'b0},
		'{1'b1, 12'h000, 8'h01, 8'h80, 8'h00, 1'b0},
		'{1'b1, 12'h004, 8'h00, 8'h80, 8'h80, 1'b0}};
	always #2.5 pclk = ~pclk;
	wwdt_cpu_model cpu (.pclk(pclk), .watchdog_tick(watchdog_tick),
		.restart_instruction(restart), .change_protection_open(prot),
		.tick_count(tick_count));
	wwdt_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .watchdog_tick(watchdog_tick),
		.restart_instruction(restart), .change_protection_open(prot),
		.debug_halt(debug_halt), .boot_config_fuse(fuse),
		.sys_reset_req(sys_reset_req),
		.watchdog_enabled(watchdog_enabled));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pw(input logic [11:0] a, input logic [31:0] d);
		cpu.key(1'b1);
		apb(1'b1, a, d);
		cpu.key(1'b0);
	endtask
	task sync_wait;
		int n;
		n = 0;
		do begin
			apb(1'b0, 12'h004, 32'h0000_0000);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		if (rd[0] !== 1'b0)
			miscompares++;
	endtask
	task align;
		@(posedge watchdog_tick);
		repeat (5) @(posedge pclk);
	endtask
	task fire(input int s, input int exp);
		int n;
		n = 0;
		while (sys_reset_req !== 1'b1 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000)
			miscompares++;
		chk(32'(tick_count - s), 32'(exp));
	endtask
	task conclude;
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0000_0000, watchdog_enabled}, 32'h0000_0000);
		foreach (rows[i]) begin
			cpu.key(rows[i].p);
			apb(1'b1, rows[i].a, {24'h00_0000, rows[i].d});
			cpu.key(1'b0);
			apb(1'b0, 12'h004, 32'h0000_0000);
			chk(rd, {24'h00_0000, rows[i].st});
			sync_wait();
			apb(1'b0, rows[i].a, 32'h0000_0000);
			chk(rd, {24'h00_0000, rows[i].rv});
			chk({31'h0000_0000, err}, {31'h0000_0000, rows[i].e});
		end
		debug_halt <= 1'b1;
		pw(12'h004, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		debug_halt <= 1'b0;
		pw(12'h000, 32'h0000_0001);
		sync_wait();
		chk({31'h0000_0000, watchdog_enabled}, 32'h0000_0001);
		t0 = tick_count;
		fire(t0, 8);
		align();
		t0 = tick_count;
		cpu.restart();
		align();
		cpu.restart();
		fire(t0, 10);
		pw(12'h000, 32'h0000_0011);
		sync_wait();
		align();
		t0 = tick_count;
		cpu.restart();
		fire(t0, 18);
		debug_halt <= 1'b1;
		repeat (400) @(posedge pclk);
		debug_halt <= 1'b0;
		align();
		t0 = tick_count;
		cpu.restart();
		repeat (4) align();
		cpu.restart();
		fire(t0, 6);
		pw(12'h000, 32'h0000_0002);
		sync_wait();
		align();
		t0 = tick_count;
		cpu.restart();
		fire(t0, 18);
		fuse <= 8'h01;
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd, 32'h0000_0080);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		conclude();
	end
endmodule
bind wwdt_core wwdt_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.debug_halt(debug_halt), .sys_reset_req(sys_reset_req),
	.watchdog_enabled(watchdog_enabled));
`default_nettype wire

// File: wwdt_tick_sync.v
// two-stage synchroniser and rising edge detector for the watchdog tick
// assumes the tick pin is far slower than pclk
`timescale 1ns/10ps
`default_nettype none

module wwdt_tick_sync (
	input wire pclk,
	input wire presetn,
	input wire tick_pin,
	output reg tick_en
);

reg meta;
reg stable;
reg stable_d;

// ----------------------------------------------------------------
// synchroniser and edge detect
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		meta <= 1'b0;
		stable <= 1'b0;
		stable_d <= 1'b0;
		tick_en <= 1'b0;
	end else begin
		meta <= tick_pin;
		stable <= meta;
		stable_d <= stable;
		tick_en <= stable & ~stable_d;
	end
end

endmodule
`default_nettype wire
